// ==== verilog/rwg_pkg.sv ====
/*
 Constants and carrier types for the register write guard.
 Assumes an 8-bit special function register bus with 8-bit addresses.
*/
package rwg_pkg;
    localparam logic [7:0] RWG_TICKET_ADDR = 8'hC7;
    localparam logic [7:0] RWG_WINDOW_ADDR = 8'hC9;
    localparam logic [7:0] RWG_WDOG_ADDR = 8'hD8;
    localparam logic [7:0] RWG_MEM_ADDR = 8'hC6;
    localparam logic [7:0] RWG_AUX_ADDR = 8'h9D;
    localparam logic [7:0] RWG_WAKE_ADDR = 8'h9F;
    localparam logic [7:0] RWG_KEY_FIRST = 8'hAA;
    localparam logic [7:0] RWG_KEY_SECOND = 8'h55;
    localparam logic [7:0] RWG_CLOSE_CODE = 8'h00;
    localparam logic [7:0] RWG_WAKE_RESET = 8'hFF;
    localparam logic [7:0] RWG_CTRL_RESET = 8'h00;
    localparam int RWG_STATUS_BIT = 0;
    localparam int RWG_WINDOW_CYCLES = 256;
    localparam int RWG_EXTEND_CYCLES = 256;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } rwg_bus_t;
    typedef enum logic [1:0] {RWG_IDLE, RWG_HALF, RWG_OPEN} rwg_seq_t;
endpackage

// ==== verilog/rwg_register_write_guard.sv ====
/*
 Write guard for critical special function registers, plus the guarded
 registers themselves. Assumes one access per cycle on a synchronous
 8-bit bus driven by the CPU, and that sys_clk stops in low power modes.
*/
`timescale 1ns/1ps
module rwg_register_write_guard
    import rwg_pkg::*;
#(
    parameter int WINDOW_CYCLES = RWG_WINDOW_CYCLES,
    parameter int EXTEND_CYCLES = RWG_EXTEND_CYCLES
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Register bus
    input wire rwg_bus_t bus,
    output logic [7:0] rdata,
    output logic rhit,
    // Guarded register contents
    output logic [7:0] watchdog_control_reg,
    output logic [7:0] memory_control_reg,
    output logic [7:0] auxiliary_control_reg,
    output logic [7:0] wakeup_mask_reg,
    // Status
    output logic ticket_unlocked_flag,
    output logic window_open_flag
);
    localparam int CW = $clog2(WINDOW_CYCLES + EXTEND_CYCLES + 1);
    localparam logic [CW-1:0] WIN_LOAD = CW'(WINDOW_CYCLES);
    localparam logic [CW-1:0] EXT_LOAD = CW'(EXTEND_CYCLES);

    rwg_seq_t ticket_seq;
    rwg_seq_t next_ticket_seq;
    logic window_half;
    logic next_window_half;
    logic [CW-1:0] window_cnt;
    logic [CW-1:0] next_window_cnt;

    // Address decode
    wire t_hit = (bus.wr | bus.rd) && bus.addr == RWG_TICKET_ADDR;
    wire w_wr = bus.wr && bus.addr == RWG_WINDOW_ADDR;
    wire wd_wr = bus.wr && bus.addr == RWG_WDOG_ADDR;
    wire mc_wr = bus.wr && bus.addr == RWG_MEM_ADDR;
    wire ac_wr = bus.wr && bus.addr == RWG_AUX_ADDR;
    wire wk_wr = bus.wr && bus.addr == RWG_WAKE_ADDR;
    wire t_open = ticket_seq == RWG_OPEN;
    wire w_open = window_cnt != '0;
    wire t_guard_wr = wd_wr | mc_wr | ac_wr;
    wire t_grant = t_open && t_guard_wr;
    wire w_grant = w_open && wk_wr;
    wire w_key2 = w_wr && window_half && bus.wdata == RWG_KEY_SECOND;

    // Ticket sequence: a granted ticket waits with no timeout
    always_comb begin
        next_ticket_seq = ticket_seq;
        if (t_hit) begin
            if (ticket_seq == RWG_OPEN) begin
                next_ticket_seq = RWG_IDLE;
            end else if (!bus.wr) begin
                next_ticket_seq = ticket_seq;
            end else if (ticket_seq == RWG_HALF &&
                         bus.wdata == RWG_KEY_SECOND) begin
                next_ticket_seq = RWG_OPEN;
            end else if (bus.wdata == RWG_KEY_FIRST) begin
                next_ticket_seq = RWG_HALF;
            end else begin
                next_ticket_seq = RWG_IDLE;
            end
        end else if (t_grant) begin
            next_ticket_seq = RWG_IDLE;
        end
    end

    // Window sequence and countdown
    always_comb begin
        next_window_half = window_half;
        next_window_cnt = window_cnt;
        if (w_open) begin
            next_window_cnt = window_cnt - 1'b1;
        end
        if (w_wr) begin
            next_window_half = bus.wdata == RWG_KEY_FIRST;
            if (w_key2) begin
                next_window_cnt = w_open ? EXT_LOAD : WIN_LOAD;
            end else if (bus.wdata == RWG_CLOSE_CODE) begin
                next_window_cnt = '0;
            end
        end
    end

    // State registers, clocked only by the CPU clock
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            ticket_seq <= RWG_IDLE;
            window_half <= 1'b0;
            window_cnt <= '0;
        end else begin
            ticket_seq <= next_ticket_seq;
            window_half <= next_window_half;
            window_cnt <= next_window_cnt;
        end
    end

    // Guarded registers
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            watchdog_control_reg <= RWG_CTRL_RESET;
            memory_control_reg <= RWG_CTRL_RESET;
            auxiliary_control_reg <= RWG_CTRL_RESET;
            wakeup_mask_reg <= RWG_WAKE_RESET;
        end else begin
            if (t_grant && wd_wr) begin
                watchdog_control_reg <= bus.wdata;
            end
            if (t_grant && mc_wr) begin
                memory_control_reg <= bus.wdata;
            end
            if (t_grant && ac_wr) begin
                auxiliary_control_reg <= bus.wdata;
            end
            if (w_grant) begin
                wakeup_mask_reg <= bus.wdata;
            end
        end
    end

    // Read path, always open
    always_comb begin
        rdata = 8'h00;
        rhit = bus.rd;
        unique case (bus.addr)
            RWG_TICKET_ADDR: rdata[RWG_STATUS_BIT] = t_open;
            RWG_WINDOW_ADDR: rdata[RWG_STATUS_BIT] = w_open;
            RWG_WDOG_ADDR: rdata = watchdog_control_reg;
            RWG_MEM_ADDR: rdata = memory_control_reg;
            RWG_AUX_ADDR: rdata = auxiliary_control_reg;
            RWG_WAKE_ADDR: rdata = wakeup_mask_reg;
            default: rhit = 1'b0;
        endcase
    end

    assign ticket_unlocked_flag = t_open;
    assign window_open_flag = w_open;

    // Checks
    ticket_unlock_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        ticket_seq == RWG_HALF && bus.wr && bus.addr == RWG_TICKET_ADDR &&
        bus.wdata == RWG_KEY_SECOND |=> ticket_unlocked_flag)
        else $error("ticket not granted after key pair");
    ticket_consumed_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        t_grant |=> !ticket_unlocked_flag)
        else $error("ticket not consumed by protected write");
    ticket_cancel_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        t_open && t_hit |=> !ticket_unlocked_flag)
        else $error("ticket port access did not cancel ticket");
    ticket_hold_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        t_open && !t_hit && !t_guard_wr |=> t_open)
        else $error("ticket lost without cause");
    locked_write_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        !t_open && wd_wr |=> $stable(watchdog_control_reg))
        else $error("watchdog control written while locked");
    window_length_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        !w_open && w_key2 |=> window_cnt == WIN_LOAD)
        else $error("window did not open with full length");
    window_close_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        w_wr && bus.wdata == RWG_CLOSE_CODE |=> !window_open_flag)
        else $error("window not closed by zero write");
    wake_guard_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        wk_wr && !w_open |=> $stable(wakeup_mask_reg))
        else $error("wake mask written outside window");
    wake_write_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        wk_wr && w_open |=> wakeup_mask_reg == $past(bus.wdata))
        else $error("wake mask write refused inside window");
    abort_seq_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        ticket_seq == RWG_HALF && bus.wr && bus.addr == RWG_TICKET_ADDR &&
        bus.wdata != RWG_KEY_SECOND |=> !t_open)
        else $error("bad second byte still unlocked");
    window_expire_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        window_cnt == CW'(1) && !w_key2 |=> !window_open_flag)
        else $error("window outlived its length");
    window_restart_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        w_open && w_key2 |=> window_cnt == EXT_LOAD)
        else $error("window not restarted by repeated key");
    ticket_read_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        bus.rd && bus.addr == RWG_TICKET_ADDR |->
        rdata == {7'h00, ticket_unlocked_flag})
        else $error("ticket port status read wrong");
    window_read_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        bus.rd && bus.addr == RWG_WINDOW_ADDR |->
        rdata == {7'h00, window_open_flag})
        else $error("window port status read wrong");
    guard_read_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        bus.rd && bus.addr == RWG_MEM_ADDR |-> rdata == memory_control_reg)
        else $error("memory control read refused");
    ticket_write_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        wd_wr && t_open |=> watchdog_control_reg == $past(bus.wdata))
        else $error("watchdog control write refused with ticket");
    aux_write_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        ac_wr && t_open |=> auxiliary_control_reg == $past(bus.wdata))
        else $error("auxiliary control write refused with ticket");
    window_abort_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        w_wr && bus.wdata != RWG_KEY_FIRST |=> !window_half)
        else $error("window key sequence not aborted");
endmodule

// ==== bench/test_register_write_guard.sv ====
/*
 Self-checking bench for the register write guard: bus access tasks
 and checked sequences. Assumes window counts shortened to 8 cycles.
*/
`timescale 1ns/1ps
module test_register_write_guard
    import rwg_pkg::*;
;
    localparam int WC = 8;
    localparam logic [7:0] TK = RWG_TICKET_ADDR;
    localparam logic [7:0] WN = RWG_WINDOW_ADDR;
    localparam logic [7:0] WK = RWG_WAKE_ADDR;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    rwg_bus_t bus = '0;
    logic [7:0] rdata, wdog, mem, aux, wake;
    logic rhit, tflag, wflag;
    logic [8:0] got;
    int errors = 0;
    int n_checks = 0;
    int cycles = 0;
    int n;
    logic [7:0] gaddr [3] = '{RWG_WDOG_ADDR, RWG_MEM_ADDR, RWG_AUX_ADDR};

    always #2 sys_clk = ~sys_clk;

    rwg_register_write_guard #(.WINDOW_CYCLES(WC), .EXTEND_CYCLES(WC)) uut (
        .sys_clk(sys_clk), .rstn(rstn), .bus(bus), .rdata(rdata),
        .rhit(rhit), .watchdog_control_reg(wdog), .memory_control_reg(mem),
        .auxiliary_control_reg(aux), .wakeup_mask_reg(wake),
        .ticket_unlocked_flag(tflag), .window_open_flag(wflag));

    task automatic final_report();
        $display("Checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input string what, input logic [8:0] exp, act);
        n_checks++;
        if (act !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, act);
        end
    endtask

    // One access, entered and left at a rising edge; read seen mid-cycle
    task automatic acc(input logic w, input logic [7:0] a, d);
        bus <= '{wr: w, rd: !w, addr: a, wdata: d};
        @(negedge sys_clk);
        got = {rhit, rdata};
        @(posedge sys_clk);
        bus <= '0;
        @(posedge sys_clk);
    endtask

    task automatic key(input logic [7:0] a);
        acc(1'b1, a, RWG_KEY_FIRST);
        acc(1'b1, a, RWG_KEY_SECOND);
    endtask

    // Open cycles; the last key access already spent the first
    task automatic span();
        n = 1;
        while (n < 40) begin
            @(negedge sys_clk);
            if (wflag !== 1'b1)
                break;
            n++;
        end
        @(posedge sys_clk);
    endtask

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            final_report();
        end
    end

    initial begin
        repeat (20) @(posedge sys_clk);
        rstn <= 1'b1;
        @(posedge sys_clk);
        chk("wake reset", RWG_WAKE_RESET, wake);
        acc(1'b0, WN, 8'h00);
        chk("window port", 9'h100, got);
        acc(1'b0, 8'h10, 8'h00);
        chk("unmapped read", 9'h000, got);
        $display("reset test done");
        foreach (gaddr[i]) begin
            acc(1'b1, gaddr[i], 8'h5A);
            acc(1'b0, gaddr[i], 8'h00);
            chk("no ticket", 9'h100, got);
            key(TK);
            chk("ticket flag", 9'h001, tflag);
            acc(1'b1, gaddr[i], 8'h3C);
            acc(1'b0, gaddr[i], 8'h00);
            chk("ticket write", 9'h13C, got);
            chk("ticket used", 9'h000, tflag);
            acc(1'b1, gaddr[i], 8'hC3);
            acc(1'b0, gaddr[i], 8'h00);
            chk("second write", 9'h13C, got);
        end
        key(TK);
        acc(1'b0, TK, 8'h00);
        chk("ticket status", 9'h101, got);
        chk("ticket cancel", 9'h000, tflag);
        acc(1'b1, RWG_MEM_ADDR, 8'h77);
        chk("cancelled write", 9'h03C, mem);
        key(TK);
        acc(1'b1, TK, RWG_KEY_FIRST);
        chk("write cancel", 9'h000, tflag);
        acc(1'b1, TK, RWG_KEY_FIRST);
        acc(1'b1, TK, 8'h33);
        acc(1'b1, TK, RWG_KEY_SECOND);
        chk("bad key", 9'h000, tflag);
        key(TK);
        repeat (300) @(posedge sys_clk);
        acc(1'b1, RWG_AUX_ADDR, 8'h81);
        chk("late write", 9'h081, aux);
        $display("ticket test done");
        acc(1'b1, WK, 8'h12);
        chk("closed wake", RWG_WAKE_RESET, wake);
        key(WN);
        acc(1'b1, WK, 8'h12);
        acc(1'b1, WK, 8'h34);
        chk("wake multi", 9'h034, wake);
        acc(1'b0, WK, 8'h00);
        chk("wake read", 9'h134, got);
        acc(1'b0, WN, 8'h00);
        chk("window open read", 9'h101, got);
        key(WN);
        span();
        chk("window length", 9'(WC), n[8:0]);
        acc(1'b1, WK, 8'h56);
        chk("expired wake", 9'h034, wake);
        key(WN);
        repeat (4) @(posedge sys_clk);
        key(WN);
        span();
        chk("restart length", 9'(WC), n[8:0]);
        key(WN);
        acc(1'b1, WN, RWG_CLOSE_CODE);
        chk("window closed", 9'h000, wflag);
        acc(1'b1, WK, 8'h78);
        chk("closed write", 9'h034, wake);
        acc(1'b1, WN, RWG_KEY_FIRST);
        acc(1'b1, WN, 8'h33);
        acc(1'b1, WN, RWG_KEY_SECOND);
        chk("window bad key", 9'h000, wflag);
        $display("window test done");
        key(TK);
        key(WN);
        acc(1'b0, TK, 8'h00);
        acc(1'b1, WN, RWG_CLOSE_CODE);
        chk("permissions off", 9'h000, {tflag, wflag});
        $display("shutdown test done");
        final_report();
    end
endmodule
